//--- design/cmtf_pkg.sv
`default_nettype none
package cmtf_pkg;
  localparam logic [1:0] IDX_CONTROL = 2'h0;
  localparam logic [1:0] IDX_TIMING = 2'h1;
  localparam logic [1:0] IDX_FILTER2 = 2'h2;
  localparam logic [1:0] IDX_TIMESTAMP = 2'h3;
  localparam int ABORT_BIT = 27;
  localparam int REQ_LSB = 24;
  localparam int CUR_LSB = 21;
  localparam int CAP_BIT = 20;
  localparam int ON_BIT = 15;
  localparam int BUSY_BIT = 11;
  localparam int PRESC_LSB = 0;
  localparam int SJW_LSB = 6;
  localparam int PROP_LSB = 8;
  localparam int PH1_LSB = 11;
  localparam int SAMPLE3_BIT = 14;
  localparam int PH2SEL_BIT = 15;
  localparam int PH2_LSB = 16;
  localparam logic [31:0] TIMING_WMASK = 32'h0007ffff;
  localparam logic [31:0] TIMING_RESET = 32'h00000000;
  localparam logic [31:0] FILTER2_RESET = 32'h00000000;
  localparam int FLT_EN_BIT = 7;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_DISABLE = 3'h1;
  localparam logic [2:0] MODE_LOOPBACK = 3'h2;
  localparam logic [2:0] MODE_LISTEN = 3'h3;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [2:0] MODE_RSVD_A = 3'h5;
  localparam logic [2:0] MODE_RSVD_B = 3'h6;
  localparam logic [2:0] MODE_LISTEN_ALL = 3'h7;
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_RUN = 3'h2,
    ST_DRAIN = 3'h4
  } cmtf_power_t;

  // Byte-lane merge of a write into the current value
  function automatic logic [31:0] cmtf_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : cmtf_merge

  // Field value plus one, as a quanta count
  function automatic logic [3:0] cmtf_len(input logic [2:0] f);
    return {1'b0, f} + 4'h1;
  endfunction : cmtf_len

  function automatic logic [3:0] cmtf_min(input logic [3:0] a, input logic [3:0] b);
    return (a < b) ? a : b;
  endfunction : cmtf_min
endpackage : cmtf_pkg
`default_nettype wire

//--- design/cmtf_filter_bank.sv
`default_nettype none
module cmtf_filter_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  output logic [31:0] q
);
  logic [31:0] q_reg;
  logic [31:0] q_next;
  assign q = q_reg;

  always_comb begin
    q_next = q_reg;
    if (we) begin
      for (int i = 0; i < 4; i++) begin
        if (be[i]) begin
          q_next[8*i + cmtf_pkg::FLT_EN_BIT] = wdata[8*i + cmtf_pkg::FLT_EN_BIT];
          if (!q_reg[8*i + cmtf_pkg::FLT_EN_BIT]) begin
            q_next[8*i +: 7] = wdata[8*i +: 7];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_reg <= cmtf_pkg::FILTER2_RESET;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  property p_locked_fields;
    @(posedge clk) disable iff (rst)
    (ce && we && be[3] && q_reg[31]) |=> (q_reg[30:24] == $past(q_reg[30:24]));
  endproperty
  a_locked_fields: assert property (p_locked_fields) else $error("filter fields changed while enabled");
endmodule : cmtf_filter_bank
`default_nettype wire

//--- design/cmtf_tq_prescaler.sv
`default_nettype none
module cmtf_tq_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [5:0] presc,
  output logic tick
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  logic [6:0] limit;
  assign tick = tick_reg;
  // Period is 2*(presc+1) clocks, so the last count is 2*presc+1
  assign limit = {presc, 1'b1};

  always_comb begin
    cnt_next = cnt_reg + 7'h01;
    tick_next = 1'b0;
    if (cnt_reg >= limit) begin
      cnt_next = 7'h00;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  // Checking aid: enabled cycles between ticks, armed only while presc holds
  logic [7:0] gap_reg;
  logic armed_reg;
  logic [5:0] presc_seen_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_reg <= 8'h00;
      armed_reg <= 1'b0;
      presc_seen_reg <= 6'h00;
    end else if (ce) begin
      presc_seen_reg <= presc;
      gap_reg <= tick_reg ? 8'h01 : gap_reg + 8'h01;
      armed_reg <= (presc == presc_seen_reg) && (armed_reg || tick_reg);
    end
  end

  property p_tick_period;
    @(posedge clk) disable iff (rst)
    (ce && tick_reg && armed_reg && presc == presc_seen_reg) |-> (gap_reg == {1'b0, limit} + 8'h01);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("quantum period wrong");
endmodule : cmtf_tq_prescaler
`default_nettype wire

//--- design/cmtf_ctrl.sv
// Our own choices: register access over Avalon-MM and the placing of the registers.
`default_nettype none
// Behaviour
// - Abort-all bit aborts transmits, self-clears when done
// - Requested mode codes: normal..listen-all, two reserved
// - Mode status shows actual mode, same codes
// - Capture latches timer on reception; else timer stops
// - Disable waits for frame; busy flag shows it
// - Propagation segment is field plus one quanta
// - Jump width is field plus one quanta
// - Quantum is two times (prescaler plus one) clocks
// - Phase two within phase one; jump within phase two
// - Timing register writable only in configuration mode
// - Filter enable bit includes filter in matching
// - Mask select picks one of four masks
// - FIFO select routes match to FIFO number
// - Filters eight to eleven, one per byte
// - Mask and FIFO fields locked while enabled
module cmtf_ctrl (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic FRAME_ACTIVE,
  input wire logic RX_VALID,
  input wire logic TX_ALL_ABORTED,
  output logic ABORT_ALL_TX,
  output logic [2:0] CURRENT_OP_MODE,
  output logic MODULE_ACTIVE_FLAG,
  output logic [15:0] RX_TIMESTAMP,
  output logic TQ_TICK,
  output logic [3:0] PROP_SEG_TQ,
  output logic [3:0] SJW_TQ,
  output logic [3:0] PHASE1_TQ,
  output logic [3:0] PHASE2_TQ,
  output logic TRIPLE_SAMPLE,
  output logic [3:0] FILTER_ENABLE,
  output logic [7:0] FILTER_MASK_SEL,
  output logic [19:0] FILTER_FIFO_SEL
);
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic on_reg;
  logic on_next;
  logic abort_reg;
  logic abort_next;
  logic cap_reg;
  logic cap_next;
  logic [2:0] req_reg;
  logic [2:0] req_next;
  logic [2:0] cur_reg;
  logic [2:0] cur_next;
  cmtf_pkg::cmtf_power_t pwr_reg;
  cmtf_pkg::cmtf_power_t pwr_next;
  logic busy_reg;
  logic busy_next;
  logic [15:0] timer_reg;
  logic [15:0] timer_next;
  logic [15:0] stamp_reg;
  logic [15:0] stamp_next;
  logic [31:0] tim_reg;
  logic [31:0] tim_next;
  logic [3:0] prop_reg;
  logic [3:0] sjw_reg;
  logic [3:0] ph1_reg;
  logic [3:0] ph2_reg;
  logic sample3_reg;
  logic [3:0] prop_next;
  logic [3:0] sjw_next;
  logic [3:0] ph1_next;
  logic [3:0] ph2_next;
  logic commit_wr;
  logic [31:0] ctl_rd;
  logic [31:0] ctl_new;
  logic [31:0] flt_q;
  logic flt_we;

  // A request is answered one cycle after it is seen; the write lands on the
  // edge where the master sees waitrequest low, so nothing commits twice
  assign commit_wr = AVS_WRITE && !wait_reg;
  assign flt_we = commit_wr && AVS_ADDRESS == cmtf_pkg::IDX_FILTER2;

  always_comb begin
    ctl_rd = 32'h00000000;
    ctl_rd[cmtf_pkg::ABORT_BIT] = abort_reg;
    ctl_rd[cmtf_pkg::REQ_LSB +: 3] = req_reg;
    ctl_rd[cmtf_pkg::CUR_LSB +: 3] = cur_reg;
    ctl_rd[cmtf_pkg::CAP_BIT] = cap_reg;
    ctl_rd[cmtf_pkg::ON_BIT] = on_reg;
    ctl_rd[cmtf_pkg::BUSY_BIT] = pwr_reg != cmtf_pkg::ST_OFF;
    ctl_new = cmtf_pkg::cmtf_merge(ctl_rd, AVS_WRITEDATA, AVS_BYTEENABLE);
  end

  // Bus answer
  always_comb begin
    wait_next = !((AVS_READ || AVS_WRITE) && wait_reg);
    rdata_next = rdata_reg;
    if (AVS_READ && wait_reg) begin
      case (AVS_ADDRESS)
        cmtf_pkg::IDX_CONTROL: rdata_next = ctl_rd;
        cmtf_pkg::IDX_TIMING: rdata_next = tim_reg;
        cmtf_pkg::IDX_FILTER2: rdata_next = flt_q;
        cmtf_pkg::IDX_TIMESTAMP: rdata_next = {timer_reg, stamp_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else if (CE) begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // Control, mode and power sequencing
  always_comb begin
    on_next = on_reg;
    req_next = req_reg;
    cap_next = cap_reg;
    abort_next = abort_reg;
    if (abort_reg && TX_ALL_ABORTED) begin
      abort_next = 1'b0;
    end
    if (commit_wr && AVS_ADDRESS == cmtf_pkg::IDX_CONTROL) begin
      on_next = ctl_new[cmtf_pkg::ON_BIT];
      req_next = ctl_new[cmtf_pkg::REQ_LSB +: 3];
      cap_next = ctl_new[cmtf_pkg::CAP_BIT];
      // Writing one sets; a set in the clearing cycle wins
      if (ctl_new[cmtf_pkg::ABORT_BIT]) begin
        abort_next = 1'b1;
      end
    end
    cur_next = cur_reg;
    // Reserved codes are never adopted; status keeps the last valid mode
    if (!FRAME_ACTIVE && req_reg != cmtf_pkg::MODE_RSVD_A && req_reg != cmtf_pkg::MODE_RSVD_B) begin
      cur_next = req_reg;
    end
    pwr_next = pwr_reg;
    case (pwr_reg)
      cmtf_pkg::ST_OFF: begin
        if (on_reg) begin
          pwr_next = cmtf_pkg::ST_RUN;
        end
      end
      cmtf_pkg::ST_RUN: begin
        if (!on_reg) begin
          pwr_next = FRAME_ACTIVE ? cmtf_pkg::ST_DRAIN : cmtf_pkg::ST_OFF;
        end
      end
      cmtf_pkg::ST_DRAIN: begin
        if (on_reg) begin
          pwr_next = cmtf_pkg::ST_RUN;
        end else if (!FRAME_ACTIVE) begin
          pwr_next = cmtf_pkg::ST_OFF;
        end
      end
      default: pwr_next = cmtf_pkg::ST_OFF;
    endcase
    // Registered so the busy pin never shows a state-decode glitch
    busy_next = pwr_next != cmtf_pkg::ST_OFF;
    // Timer frozen while capture is off, which saves its toggling power
    timer_next = cap_reg ? timer_reg + 16'h0001 : timer_reg;
    stamp_next = stamp_reg;
    if (cap_reg && RX_VALID) begin
      stamp_next = timer_reg;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      on_reg <= 1'b0;
      req_reg <= cmtf_pkg::MODE_CONFIG;
      cur_reg <= cmtf_pkg::MODE_CONFIG;
      cap_reg <= 1'b0;
      abort_reg <= 1'b0;
      pwr_reg <= cmtf_pkg::ST_OFF;
      busy_reg <= 1'b0;
      timer_reg <= 16'h0000;
      stamp_reg <= 16'h0000;
    end else if (CE) begin
      on_reg <= on_next;
      req_reg <= req_next;
      cur_reg <= cur_next;
      cap_reg <= cap_next;
      abort_reg <= abort_next;
      pwr_reg <= pwr_next;
      busy_reg <= busy_next;
      timer_reg <= timer_next;
      stamp_reg <= stamp_next;
    end
  end

  // Bit timing
  always_comb begin
    tim_next = tim_reg;
    if (commit_wr && AVS_ADDRESS == cmtf_pkg::IDX_TIMING && cur_reg == cmtf_pkg::MODE_CONFIG) begin
      tim_next = cmtf_pkg::cmtf_merge(tim_reg, AVS_WRITEDATA, AVS_BYTEENABLE) & cmtf_pkg::TIMING_WMASK;
    end
    prop_next = cmtf_pkg::cmtf_len(tim_reg[cmtf_pkg::PROP_LSB +: 3]);
    ph1_next = cmtf_pkg::cmtf_len(tim_reg[cmtf_pkg::PH1_LSB +: 3]);
    // Automatic phase two equals phase one; a programmed one is clipped to it
    ph2_next = ph1_next;
    if (tim_reg[cmtf_pkg::PH2SEL_BIT]) begin
      ph2_next = cmtf_pkg::cmtf_min(cmtf_pkg::cmtf_len(tim_reg[cmtf_pkg::PH2_LSB +: 3]), ph1_next);
    end
    sjw_next = cmtf_pkg::cmtf_min(cmtf_pkg::cmtf_len({1'b0, tim_reg[cmtf_pkg::SJW_LSB +: 2]}), ph2_next);
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tim_reg <= cmtf_pkg::TIMING_RESET;
      prop_reg <= 4'h1;
      ph1_reg <= 4'h1;
      ph2_reg <= 4'h1;
      sjw_reg <= 4'h1;
      sample3_reg <= 1'b0;
    end else if (CE) begin
      tim_reg <= tim_next;
      prop_reg <= prop_next;
      ph1_reg <= ph1_next;
      ph2_reg <= ph2_next;
      sjw_reg <= sjw_next;
      // Legality of triple sampling is left to software
      sample3_reg <= tim_reg[cmtf_pkg::SAMPLE3_BIT];
    end
  end

  cmtf_tq_prescaler u_presc (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .presc(tim_reg[cmtf_pkg::PRESC_LSB +: 6]),
    .tick(TQ_TICK)
  );

  cmtf_filter_bank u_filters (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .we(flt_we),
    .be(AVS_BYTEENABLE),
    .wdata(AVS_WRITEDATA),
    .q(flt_q)
  );

  // Byte n holds filter 8+n: enable, mask select, FIFO select
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      FILTER_ENABLE[i] = flt_q[8*i + 7];
      FILTER_MASK_SEL[2*i +: 2] = flt_q[8*i + 5 +: 2];
      FILTER_FIFO_SEL[5*i +: 5] = flt_q[8*i +: 5];
    end
  end

  assign AVS_READDATA = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign ABORT_ALL_TX = abort_reg;
  assign CURRENT_OP_MODE = cur_reg;
  assign MODULE_ACTIVE_FLAG = busy_reg;
  assign RX_TIMESTAMP = stamp_reg;
  assign PROP_SEG_TQ = prop_reg;
  assign SJW_TQ = sjw_reg;
  assign PHASE1_TQ = ph1_reg;
  assign PHASE2_TQ = ph2_reg;
  assign TRIPLE_SAMPLE = sample3_reg;

  property p_abort_clear;
    @(posedge SYS_CLK) disable iff (RST)
    (CE && abort_reg && TX_ALL_ABORTED && !commit_wr) |=> !abort_reg;
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("abort not cleared");

  property p_req_store;
    @(posedge SYS_CLK) disable iff (RST)
    (CE && commit_wr && AVS_ADDRESS == cmtf_pkg::IDX_CONTROL && AVS_BYTEENABLE[3])
      |=> req_reg == $past(AVS_WRITEDATA[26:24]);
  endproperty
  a_req_store: assert property (p_req_store) else $error("requested mode not stored");

  property p_mode_between_frames;
    @(posedge SYS_CLK) disable iff (RST)
    (cur_reg != $past(cur_reg)) |-> ($past(!FRAME_ACTIVE) && cur_reg == $past(req_reg));
  endproperty
  a_mode_between_frames: assert property (p_mode_between_frames) else $error("mode changed mid frame");

  property p_stamp;
    @(posedge SYS_CLK) disable iff (RST)
    (CE && cap_reg && RX_VALID) |=> stamp_reg == $past(timer_reg);
  endproperty
  a_stamp: assert property (p_stamp) else $error("timestamp not captured");

  property p_busy_drain;
    @(posedge SYS_CLK) disable iff (RST)
    (CE && !on_reg && pwr_reg != cmtf_pkg::ST_OFF) |=> (MODULE_ACTIVE_FLAG == $past(FRAME_ACTIVE));
  endproperty
  a_busy_drain: assert property (p_busy_drain) else $error("busy flag wrong while disabling");

  property p_prop_len;
    @(posedge SYS_CLK) disable iff (RST)
    CE ##1 CE |-> PROP_SEG_TQ == {1'b0, $past(tim_reg[10:8])} + 4'h1;
  endproperty
  a_prop_len: assert property (p_prop_len) else $error("propagation length wrong");

  property p_timing_lock;
    @(posedge SYS_CLK) disable iff (RST)
    (CE && commit_wr && AVS_ADDRESS == cmtf_pkg::IDX_TIMING && cur_reg != cmtf_pkg::MODE_CONFIG)
      |=> tim_reg == $past(tim_reg);
  endproperty
  a_timing_lock: assert property (p_timing_lock) else $error("timing written outside config");
endmodule : cmtf_ctrl
`default_nettype wire

//--- bench/cmtf_frame_model.sv
`default_nettype none
module cmtf_frame_model #(
  parameter int FRAME_LEN = 20,
  parameter int ABORT_LAT = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic abort_req,
  output logic frame_active,
  output logic rx_valid,
  output logic tx_all_aborted
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  int ab_cnt;
  // A frame is a busy window ending in one received message
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      frame_active <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= (cnt == 1);
      if (go && cnt == 0) begin
        cnt <= FRAME_LEN;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
      frame_active <= (go && cnt == 0) || cnt > 1;
    end
  end
  // Buffers take a few cycles to abandon work, never instantly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ab_cnt <= 0;
      tx_all_aborted <= 1'b0;
    end else begin
      ab_cnt <= abort_req ? ab_cnt + 1 : 0;
      tx_all_aborted <= abort_req && ab_cnt >= ABORT_LAT;
    end
  end
endmodule : cmtf_frame_model
`default_nettype wire

//--- bench/cmtf_ctrl_tb_top.sv
`default_nettype none
module cmtf_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] addr = 2'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdat;
  logic wreq, fa, rxv, txab, abrt, busy, tick, trip;
  logic go = 1'b0;
  logic [2:0] mode;
  logic [15:0] stamp;
  logic [3:0] prop, resync_jump_width, ph1, ph2, fen;
  logic [7:0] fmsk;
  logic [19:0] ffifo;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  cmtf_ctrl u_dut (.SYS_CLK(clk), .RST(rst), .CE(ce), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .FRAME_ACTIVE(fa), .RX_VALID(rxv), .TX_ALL_ABORTED(txab), .ABORT_ALL_TX(abrt), .CURRENT_OP_MODE(mode),
    .MODULE_ACTIVE_FLAG(busy), .RX_TIMESTAMP(stamp), .TQ_TICK(tick), .PROP_SEG_TQ(prop), .SJW_TQ(resync_jump_width),
    .PHASE1_TQ(ph1), .PHASE2_TQ(ph2), .TRIPLE_SAMPLE(trip), .FILTER_ENABLE(fen), .FILTER_MASK_SEL(fmsk),
    .FILTER_FIFO_SEL(ffifo));
  cmtf_frame_model u_far (.clk(clk), .rst(rst), .go(go), .abort_req(abrt), .frame_active(fa), .rx_valid(rxv),
    .tx_all_aborted(txab));
  task final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      final_report();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // Request held until waitrequest is sampled low; one idle edge keeps requests apart
  task bus(input logic w, input logic [1:0] a, input logic [31:0] d, input logic [3:0] b, output logic [31:0] r);
    addr <= a;
    wdat <= d;
    be <= b;
    wr <= w;
    rd <= ~w;
    // Only the bench's cycle ceiling ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  task wr32(input logic [1:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
    logic [31:0] r;
    bus(1'b1, a, d, b, r);
  endtask : wr32
  task rd32(input logic [1:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, 4'hf, r);
  endtask : rd32
  function automatic logic [31:0] ctl(input logic ab, input logic [2:0] m, input logic cap, input logic on);
    return {4'h0, ab, m, 3'h0, cap, 4'h0, on, 15'h0};
  endfunction : ctl
  task wait_frame_end();
    int n;
    n = 0;
    while (fa !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    idle(3);
  endtask : wait_frame_end
  task start_frame();
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    idle(2);
  endtask : start_frame
  task t_reset();
    logic [31:0] r;
    chk(mode, 3'h4);
    chk({prop, resync_jump_width, ph1, ph2}, 16'h1111);
    chk({trip, fen, abrt, busy, tick}, 8'h00);
    rd32(2'h1, r);
    chk(r, 32'h0);
    rd32(2'h2, r);
    chk(r, 32'h0);
  endtask : t_reset
  task t_timing();
    logic [31:0] r;
    logic [5:0] pv [3];
    int per [3];
    int c;
    pv = '{6'h00, 6'h03, 6'h3f};
    per = '{2, 8, 128};
    // Eight quanta each for prop and phase one keep the bit above seven quanta
    wr32(2'h1, 32'h0002ffc3);
    idle(3);
    rd32(2'h1, r);
    chk(r, 32'h0002ffc3);
    chk({prop, ph1, ph2, resync_jump_width, 3'h0, trip}, 20'h88331);
    wr32(2'h1, 32'h000017c3);
    idle(3);
    chk({ph1, ph2, resync_jump_width}, 12'h333);
    for (int i = 0; i < 3; i++) begin
      wr32(2'h1, {18'h0, 8'h3f, pv[i]});
      idle(3);
      chk({prop, resync_jump_width}, 8'h82);
      repeat (2) begin
        c = 0;
        do begin
          @(posedge clk);
          c++;
        end while (tick !== 1'b1 && c < 300);
      end
      c = 0;
      do begin
        @(posedge clk);
        c++;
      end while (tick !== 1'b1 && c < 300);
      chk(c, per[i]);
    end
  endtask : t_timing
  task t_frame_mode();
    start_frame();
    wr32(2'h0, ctl(1'b0, 3'h0, 1'b0, 1'b0));
    idle(3);
    chk(mode, 3'h4);
    wait_frame_end();
    chk(mode, 3'h0);
  endtask : t_frame_mode
  task t_modes();
    logic [2:0] codes [7];
    logic [2:0] ex;
    codes = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h5, 3'h6, 3'h0};
    ex = 3'h0;
    for (int i = 0; i < 7; i++) begin
      wr32(2'h0, ctl(1'b0, codes[i], 1'b0, 1'b0));
      idle(3);
      if (codes[i] != 3'h5 && codes[i] != 3'h6) ex = codes[i];
      chk(mode, ex);
    end
  endtask : t_modes
  task t_lock();
    logic [31:0] r;
    wr32(2'h1, 32'h00000001);
    rd32(2'h1, r);
    chk(r, 32'h00000fff);
    wr32(2'h0, ctl(1'b0, 3'h4, 1'b0, 1'b0));
    idle(3);
  endtask : t_lock
  task t_abort();
    logic [31:0] r;
    wr32(2'h0, ctl(1'b1, 3'h4, 1'b0, 1'b0));
    chk(abrt, 1'b1);
    idle(12);
    chk(abrt, 1'b0);
    rd32(2'h0, r);
    chk(r[27:21], 7'h24);
  endtask : t_abort
  task t_busy();
    logic [31:0] r;
    wr32(2'h0, ctl(1'b0, 3'h4, 1'b0, 1'b1));
    idle(2);
    rd32(2'h0, r);
    chk({busy, r[11]}, 2'h3);
    start_frame();
    wr32(2'h0, ctl(1'b0, 3'h4, 1'b0, 1'b0));
    idle(3);
    chk(busy, 1'b1);
    wait_frame_end();
    rd32(2'h0, r);
    chk({busy, r[11]}, 2'h0);
  endtask : t_busy
  task t_stamp();
    logic [31:0] a, b;
    rd32(2'h3, a);
    rd32(2'h3, b);
    chk(b[31:16], a[31:16]);
    wr32(2'h0, ctl(1'b0, 3'h4, 1'b1, 1'b0));
    rd32(2'h3, a);
    rd32(2'h3, b);
    chk(b[31:16] - a[31:16], 16'h3);
    start_frame();
    wait_frame_end();
    rd32(2'h3, a);
    chk(stamp !== 16'h0 && stamp === a[15:0], 1'b1);
  endtask : t_stamp
  // Enable low for five edges: the timer must not count them
  task t_hold();
    logic [31:0] a, b;
    rd32(2'h3, a);
    ce <= 1'b0;
    idle(5);
    ce <= 1'b1;
    rd32(2'h3, b);
    chk(b[31:16] - a[31:16], 16'h3);
  endtask : t_hold
  task t_filters();
    logic [31:0] w, r;
    logic [31:0] wd [5];
    logic [31:0] ex [5];
    logic [3:0] bs [5];
    wd = '{32'h7f3a5c01, 32'hff000000, 32'h81000000, 32'h01000000, 32'h05000000};
    bs = '{4'hf, 4'h8, 4'h8, 4'h8, 4'h8};
    ex = '{32'h7f3a5c01, 32'hff3a5c01, 32'hff3a5c01, 32'h7f3a5c01, 32'h053a5c01};
    for (int i = 0; i < 5; i++) begin
      wr32(2'h2, wd[i], bs[i]);
      rd32(2'h2, r);
      w = ex[i];
      chk(r, w);
      chk({fen, fmsk}, {w[31], w[23], w[15], w[7], w[30:29], w[22:21], w[14:13], w[6:5]});
      chk(ffifo, {w[28:24], w[20:16], w[12:8], w[4:0]});
    end
  endtask : t_filters
  initial begin
    idle(12);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_timing();
    t_frame_mode();
    t_modes();
    t_lock();
    t_abort();
    t_busy();
    t_stamp();
    t_hold();
    t_filters();
    final_report();
  end
endmodule : cmtf_ctrl_tb_top
`default_nettype wire
